// *** rtl/card_reader_abnormal_indicators.sv ***
// abnormal-condition indicators of the card reader synchronizer
// assumes pins are asynchronous, memory-side events share clk
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - fault only online with standby or cards
// - fault blocks memory until cleared thrice
// - oversight online with standby or cards, or on offline standby
// - oversight blocks memory until cleared thrice
// - stacker-section cards go to program stacker
// - stations 1-4 to stacker 0 at end
// - fault outranks data error and oversight
// - oversight outranks data error
// - hole count mismatch sets data error
// - data address error sets data error
// - wrong access count sets data error
// - transfer modulo-3 error sets data error
// - memory modulo-3 error sets data error
// - feed jam stops motor, sets fault
// - stacker jam stops motor, sets fault
// - specifier address error sets fault
// - specifier modulo-3 error sets fault
// - logic check failure sets fault
// - open door sets oversight and lamps
// - full stacker sets oversight
// - no card after feed sets oversight
// - motor press or offline standby: oversight
// - data error: standby fetch, then block
// - data error interrupt at next cycle
module card_reader_abnormal_indicators
	import abn_pkg::*;
#(
	parameter int COLUMNS = 80,
	parameter int HOLE_W  = 10
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire transport_pins_t   pins,
	input  wire sync_events_t      ev,
	input  wire logic [HOLE_W-1:0] holes_rs1,
	input  wire logic [HOLE_W-1:0] holes_rs2,
	input  wire logic              holes_valid,
	input  wire logic [3:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_we,
	input  wire logic              reg_re,
	output logic [31:0]            reg_rdata,
	output logic                   data_error_ind,
	output logic                   fault_ind,
	output logic                   oversight_ind,
	output logic                   mem_inhibit,
	output logic                   standby_fetch,
	output logic                   drive_motor,
	output logic [1:0]             stacker_section_route,
	output logic                   divert_to_stacker0,
	output lamps_t                 lamps
);

	// refuse column counts that have no access figure, and empty hole counts
	if ((COLUMNS != 80 && COLUMNS != 90) || HOLE_W < 1) begin : g_bad_params
		$error("COLUMNS must be 80 or 90 and HOLE_W at least 1");
	end

	localparam logic [COUNT_W-1:0] EXPECTED =
		(COLUMNS == 80) ? COUNT_W'(ACCESSES_80) : COUNT_W'(ACCESSES_90);

	// two-stage synchronisers for every pin
	logic [NUM_PINS-1:0] pin_meta_q;   // first stage, read only by stage two
	logic [NUM_PINS-1:0] pin_sync_q;   // safe for logic
	transport_pins_t     p;            // synchronised view
	transport_pins_t     p_prev_q;     // for edge detection

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++) begin : g_sync
			// double flop per pin
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					pin_meta_q[gi] <= 1'b0;
					pin_sync_q[gi] <= 1'b0;
				end else begin
					pin_meta_q[gi] <= pins[gi];
					pin_sync_q[gi] <= pin_meta_q[gi];
				end
			end
		end
	endgenerate

	assign p = transport_pins_t'(pin_sync_q);

	// previous synchronised pin values
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			p_prev_q <= '0;
		end else begin
			p_prev_q <= p;
		end
	end

	// rising edges of synchronised pins
	logic cycle_start;      // new card cycle begins
	logic motor_press;      // motor button pressed
	logic abn_press;        // abnormal clear pressed
	logic rderr_press;      // read error button-light pressed
	assign cycle_start = p.card_cycle & ~p_prev_q.card_cycle;
	assign motor_press = p.motor_button & ~p_prev_q.motor_button;
	assign abn_press   = p.abnormal_clear_button & ~p_prev_q.abnormal_clear_button;
	assign rderr_press = p.read_error_button & ~p_prev_q.read_error_button;

	// qualifying state: online and standby set or cards in path
	logic qualified;
	logic operating;
	assign operating = ev.standby_interlock | p.cards_in_path;
	assign qualified = p.online & operating;

	// raw condition detection
	logic hole_mismatch;    // check-read error
	logic access_bad;       // access count error
	logic fault_cond;       // any fault source
	logic over_cond;        // any oversight source
	logic data_cond;        // any data error source
	logic no_card;          // empty magazine after feed
	logic offline_standby;  // standby set while offline
	logic [COUNT_W-1:0] access_cnt_q;

	assign hole_mismatch = holes_valid & (holes_rs1 != holes_rs2);
	assign access_bad = ev.image_done &
		((access_cnt_q + COUNT_W'(ev.mem_grant)) != EXPECTED);
	assign no_card = ev.fs_done & ev.fs_feed & ~p.card_at_rs1;
	assign offline_standby = ev.io_function_instruction & ~p.online;

	assign data_cond = hole_mismatch | access_bad | ev.data_addr_err |
		ev.xfer_mod3_err | ev.data_mod3_err;

	assign fault_cond = qualified & (p.feed_jam | p.stack_jam | ev.fs_addr_err |
		ev.fs_mod3_err | ev.logic_check_err);

	assign over_cond = (qualified & (p.door_open | p.stacker_full | no_card |
		motor_press)) | offline_standby;

	// accesses granted for the current image
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			access_cnt_q <= '0;
		end else if (ev.image_done) begin
			access_cnt_q <= '0;
		end else if (ev.mem_grant) begin
			access_cnt_q <= access_cnt_q + COUNT_W'(1);
		end
	end

	// per card cycle bookkeeping
	logic fault_seen_q;     // fault already this cycle
	logic over_seen_q;      // oversight already this cycle
	logic data_pend_q;      // data error waiting for next cycle
	logic data_commit;      // data error raised now

	// data error held to next cycle start
	assign data_commit = cycle_start & data_pend_q & ~fault_seen_q &
		~over_seen_q & ~fault_cond & ~over_cond;

	// cycle flags restart at each cycle boundary
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_seen_q <= 1'b0;
			over_seen_q  <= 1'b0;
			data_pend_q  <= 1'b0;
		end else if (cycle_start) begin
			fault_seen_q <= fault_cond;
			over_seen_q  <= over_cond;
			data_pend_q  <= data_cond;
		end else begin
			fault_seen_q <= fault_seen_q | fault_cond;
			over_seen_q  <= over_seen_q | over_cond;
			data_pend_q  <= data_pend_q | data_cond;
		end
	end

	// software clears, write one to clear
	logic status_wr;
	logic clr_data;
	logic clr_fault;
	logic clr_over;
	assign status_wr = reg_we & (reg_addr == STATUS_OFS);
	assign clr_data  = status_wr & reg_wdata[ST_DATA_BIT];
	assign clr_fault = status_wr & reg_wdata[ST_FAULT_BIT];
	assign clr_over  = status_wr & reg_wdata[ST_OVER_BIT];

	// indicators; set beats a same-cycle clear
	logic data_q;
	logic fault_q;
	logic over_q;
	logic over_set;
	// oversight loses to a fault in the same cycle
	assign over_set = over_cond & ~fault_cond & ~fault_seen_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			data_q  <= 1'b0;
			fault_q <= 1'b0;
			over_q  <= 1'b0;
		end else begin
			// fault set at once, clears an oversight set this cycle
			if (fault_cond) begin
				fault_q <= 1'b1;
			end else if (clr_fault) begin
				fault_q <= 1'b0;
			end
			if (over_set) begin
				over_q <= 1'b1;
			end else if (clr_over || (fault_cond && over_seen_q && !cycle_start)) begin
				over_q <= 1'b0;
			end
			if (data_commit) begin
				data_q <= 1'b1;
			end else if (clr_data) begin
				data_q <= 1'b0;
			end
		end
	end

	// abnormal latch: waits for correction plus abnormal clear
	logic abn_q;
	logic cond_gone;
	assign cond_gone = ~(p.feed_jam | p.stack_jam | p.door_open | p.stacker_full);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			abn_q <= 1'b0;
		end else if (fault_cond || over_set) begin
			abn_q <= 1'b1;
		end else if (abn_press && cond_gone) begin
			abn_q <= 1'b0;
		end
	end

	// one standby fetch after a data error
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			standby_fetch <= 1'b0;
		end else begin
			standby_fetch <= data_commit;
		end
	end

	// memory blocked until all three are done
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_inhibit <= 1'b0;
		end else begin
			mem_inhibit <= fault_q | over_q | abn_q | fault_cond | over_set |
				(data_q & ~standby_fetch);
		end
	end

	// drive motor: started by the button, stopped by jams
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			drive_motor <= 1'b0;
		end else if (p.feed_jam || p.stack_jam) begin
			drive_motor <= 1'b0;
		end else if (motor_press && !drive_motor) begin
			drive_motor <= 1'b1;
		end
	end

	// lamps latch; all but read error go out on abnormal clear once corrected
	lamps_t lamps_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lamps_q <= '0;
		end else begin
			// read error lamp; its own button clears it
			if (hole_mismatch || access_bad) begin
				lamps_q.read_error <= 1'b1;
			end else if (rderr_press) begin
				lamps_q.read_error <= 1'b0;
			end
			if (fault_cond && p.feed_jam) begin
				lamps_q.feed_jam <= 1'b1;
			end else if (abn_press && cond_gone) begin
				lamps_q.feed_jam <= 1'b0;
			end
			if (fault_cond && p.stack_jam) begin
				lamps_q.stack_jam <= 1'b1;
			end else if (abn_press && cond_gone) begin
				lamps_q.stack_jam <= 1'b0;
			end
			if (over_cond && p.door_open) begin
				lamps_q.interlock <= 1'b1;
			end else if (abn_press && cond_gone) begin
				lamps_q.interlock <= 1'b0;
			end
			if (fault_cond || over_set) begin
				lamps_q.abnormal_clear <= 1'b1;
			end else if (abn_press && cond_gone) begin
				lamps_q.abnormal_clear <= 1'b0;
			end
			if (over_cond && p.stacker_full) begin
				lamps_q.stack_full <= 1'b1;
			end else if (abn_press && cond_gone) begin
				lamps_q.stack_full <= 1'b0;
			end
			if (over_cond && no_card) begin
				lamps_q.no_card_lamp <= 1'b1;
			end else if (abn_press && cond_gone) begin
				lamps_q.no_card_lamp <= 1'b0;
			end
		end
	end
	assign lamps = lamps_q;

	// program stacker selection, software written
	logic [1:0] control_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			control_q <= CONTROL_RST;
		end else if (reg_we && reg_addr == CONTROL_OFS) begin
			control_q <= reg_wdata[1:0];
		end
	end

	// stacker section follows the program choice
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stacker_section_route <= STACKER_0;
		end else begin
			stacker_section_route <= control_q;
		end
	end

	// interrupt pending until the current specifier ends
	logic intr_pend_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			intr_pend_q        <= 1'b0;
			divert_to_stacker0 <= 1'b0;
		end else begin
			// stations 1-4 to stacker 0 at specifier end
			divert_to_stacker0 <= ev.fs_done & (intr_pend_q | fault_cond | over_set);
			if (fault_cond || over_set) begin
				intr_pend_q <= ~ev.fs_done;
			end else if (ev.fs_done) begin
				intr_pend_q <= 1'b0;
			end
		end
	end

	// register read, data one cycle after the strobe
	logic [31:0] status_word;
	always_comb begin
		status_word = '0;
		status_word[ST_DATA_BIT]  = data_q;
		status_word[ST_FAULT_BIT] = fault_q;
		status_word[ST_OVER_BIT]  = over_q;
		status_word[ST_INH_BIT]   = mem_inhibit;
		status_word[ST_ABN_BIT]   = abn_q;
		status_word[ST_LAMP_LSB +: NUM_LAMPS] = lamps_q;
	end

	// unmapped offsets read zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_re) begin
			unique case (reg_addr)
				STATUS_OFS:  reg_rdata <= status_word;
				CONTROL_OFS: reg_rdata <= {30'h0, control_q};
				COUNT_OFS:   reg_rdata <= {{(32-COUNT_W){1'b0}}, access_cnt_q};
				default:     reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	assign data_error_ind = data_q;
	assign fault_ind      = fault_q;
	assign oversight_ind  = over_q;

endmodule

`default_nettype wire

// *** common/abn_pkg.sv ***
// shared constants and carriers for the card reader abnormal indicator block
// assumes a single 200 MHz clock and a plain register port
package abn_pkg;
	// register offsets (byte addresses)
	localparam logic [3:0] STATUS_OFS  = 4'h0;
	localparam logic [3:0] CONTROL_OFS = 4'h4;
	localparam logic [3:0] COUNT_OFS   = 4'h8;
	// status field positions
	localparam int ST_DATA_BIT  = 0;
	localparam int ST_FAULT_BIT = 1;
	localparam int ST_OVER_BIT  = 2;
	localparam int ST_INH_BIT   = 3;
	localparam int ST_ABN_BIT   = 4;
	localparam int ST_LAMP_LSB  = 5;
	// control reset value: program stacker 0
	localparam logic [1:0] CONTROL_RST = 2'h0;
	// stacker codes
	localparam logic [1:0] STACKER_0 = 2'h0;
	// memory accesses granted per card image
	localparam int ACCESSES_80 = 480;
	localparam int ACCESSES_90 = 288;
	localparam int COUNT_W     = 9;
	// synchroniser depth for pins
	localparam int SYNC_STAGES = 2;
	localparam int NUM_PINS    = 12;

	// transport and panel pins, all asynchronous to clk
	typedef struct packed {
		logic       online;
		logic       cards_in_path;
		logic       card_cycle;
		logic       card_at_rs1;
		logic       feed_jam;
		logic       stack_jam;
		logic       door_open;
		logic       stacker_full;
		logic       motor_button;
		logic       abnormal_clear_button;
		logic       read_error_button;
		logic       spare;
	} transport_pins_t;

	// events from the synchroniser's own memory and check logic, same clock
	typedef struct packed {
		logic mem_grant;
		logic image_done;
		logic data_addr_err;
		logic data_mod3_err;
		logic xfer_mod3_err;
		logic fs_addr_err;
		logic fs_mod3_err;
		logic logic_check_err;
		logic fs_done;
		logic fs_feed;
		logic io_function_instruction;
		logic standby_interlock;
	} sync_events_t;

	// panel lamps
	typedef struct packed {
		logic read_error;
		logic feed_jam;
		logic stack_jam;
		logic interlock;
		logic abnormal_clear;
		logic stack_full;
		logic no_card_lamp;
	} lamps_t;
	localparam int NUM_LAMPS = 7;
endpackage

// *** verif/mem_channel_model.sv ***
// memory channel model: hands out grants for one card image
// assumes the block counts grants and inhibits memory when abnormal
`timescale 1ns/1ps
`default_nettype none
module mem_channel_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       start,
	input  wire logic [9:0] n_grant,
	input  wire logic       slow,
	input  wire logic       mem_inhibit,
	output logic            grant,
	output logic            done
);
	logic [9:0] left_q; // grants still owed
	logic       gap_q;  // idle phase when slow
	// grants stop while inhibited, so a blocked image simply stalls
	// grant count per image
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			left_q <= 10'h000;
			gap_q <= 1'h0;
			grant <= 1'h0;
			done <= 1'h0;
		end else begin
			grant <= 1'h0;
			done <= 1'h0;
			gap_q <= slow & ~gap_q;
			if (start) begin
				left_q <= n_grant;
			end else if (left_q != 10'h000 && !mem_inhibit && !gap_q) begin
				// done rides with the last grant
				grant <= 1'h1;
				done <= left_q == 10'h001;
				left_q <= left_q - 10'h001;
			end
		end
	end
endmodule
`default_nettype wire

// *** verif/abn_checker.sv ***
// port assertions for the abnormal indicator block
// assumes one clock domain, attached by bind below
`timescale 1ns/1ps
`default_nettype none
module abn_checker
	import abn_pkg::*;
(
	input wire logic            clk,
	input wire logic            rst_n,
	input wire transport_pins_t pins,
	input wire sync_events_t    ev,
	input wire logic [3:0]      reg_addr,
	input wire logic [31:0]     reg_wdata,
	input wire logic            reg_we,
	input wire logic            data_error_ind,
	input wire logic            fault_ind,
	input wire logic            oversight_ind,
	input wire logic            mem_inhibit,
	input wire logic            standby_fetch,
	input wire logic            drive_motor,
	input wire logic [1:0]      stacker_section_route,
	input wire logic            divert_to_stacker0,
	input wire lamps_t          lamps
);
	logic [2:0] on_q;  // qualified, last samples
	logic [3:0] off_q; // offline, last samples
	logic [1:0] ctl_q; // last stacker code written
	logic       st_wr; // status write now
	// pin history reset too, so the sync delay is covered
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			on_q <= 3'h0;
			off_q <= 4'h0;
			ctl_q <= CONTROL_RST;
		end else begin
			on_q <= {on_q[1:0], pins.online & pins.cards_in_path};
			off_q <= {off_q[2:0], ~pins.online};
			if (reg_we && reg_addr == CONTROL_OFS) begin
				ctl_q <= reg_wdata[1:0];
			end
		end
	end
	assign st_wr = reg_we && reg_addr == STATUS_OFS;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence jam_s;
		(pins.feed_jam || pins.stack_jam) && &on_q;
	endsequence
	sequence fetch_s;
		standby_fetch ##1 data_error_ind [*3];
	endsequence
	fault_set_a:
	assert property ((ev.fs_addr_err || ev.fs_mod3_err || ev.logic_check_err) && &on_q |=> fault_ind)
		else $error("fault not set");
	fault_gate_a:
	assert property (&off_q |=> !$rose(fault_ind)) else $error("fault set offline");
	fault_hold_a:
	assert property (fault_ind && !(st_wr && reg_wdata[ST_FAULT_BIT]) |=> fault_ind) else $error("fault lost");
	over_hold_a:
	assert property (oversight_ind && !(st_wr && reg_wdata[ST_OVER_BIT]) |=> oversight_ind || fault_ind)
		else $error("oversight lost");
	data_hold_a:
	assert property (data_error_ind && !(st_wr && reg_wdata[ST_DATA_BIT]) |=> data_error_ind)
		else $error("data error lost");
	abn_block_a:
	assert property ((fault_ind || oversight_ind) [*2] |-> mem_inhibit) else $error("memory not blocked");
	data_block_a:
	assert property (fetch_s |-> mem_inhibit) else $error("memory open after fetch");
	motor_stop_a:
	assert property (jam_s |-> ##[0:4] !drive_motor) else $error("motor runs on jam");
	divert_end_a:
	assert property (divert_to_stacker0 |-> $past(ev.fs_done)) else $error("divert off specifier end");
	route_prog_a:
	assert property (!(reg_we && reg_addr == CONTROL_OFS) [*2] |-> stacker_section_route == ctl_q)
		else $error("route not program stacker");
	// a qualified pin condition reaches its lamp after the two sync stages and one latch edge
	feed_lamp_a:
	assert property (pins.feed_jam && pins.online && pins.cards_in_path |-> ##3 lamps.feed_jam)
		else $error("feed jam lamp dark");
	stack_lamp_a:
	assert property (pins.stack_jam && pins.online && pins.cards_in_path |-> ##3 lamps.stack_jam)
		else $error("stacker jam lamp dark");
	door_lamp_a:
	assert property (pins.door_open && pins.online && pins.cards_in_path |-> ##3
		(lamps.interlock && lamps.abnormal_clear)) else $error("door lamps dark");
	full_lamp_a:
	assert property (pins.stacker_full && pins.online && pins.cards_in_path |-> ##3 lamps.stack_full)
		else $error("stacker full lamp dark");
endmodule
bind card_reader_abnormal_indicators abn_checker u_chk (.clk(clk), .rst_n(rst_n), .pins(pins), .ev(ev),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .data_error_ind(data_error_ind),
	.fault_ind(fault_ind), .oversight_ind(oversight_ind), .mem_inhibit(mem_inhibit),
	.standby_fetch(standby_fetch), .drive_motor(drive_motor), .stacker_section_route(stacker_section_route),
	.divert_to_stacker0(divert_to_stacker0), .lamps(lamps));
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the abnormal indicator block
// assumes the memory channel model and a 200 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb;
	import abn_pkg::*;
	logic        clk = 1'h0;
	logic        rst_n = 1'h0;
	logic [11:0] base = 12'hc00;  // online, cards in path
	logic [11:0] pin_q = 12'h000; // transport pins
	logic [11:0] ev_q = 12'h000;  // bench events
	logic [9:0]  h1 = 10'h000;    // station 1 holes
	logic [9:0]  h2 = 10'h000;    // station 2 holes
	logic        hv = 1'h0;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wd = 32'h0;
	logic        we = 1'h0;
	logic        re = 1'h0;
	logic        rd_q = 1'h0;     // read answer due
	logic        st = 1'h0;       // start an image
	logic [9:0]  ng = 10'h000;
	logic        slow = 1'h0;
	logic [15:0] lf = 16'h2d6b;   // seed
	logic [31:0] rdata;
	logic        inh;
	logic        grant;
	logic        done;
	sync_events_t evw;
	logic [3:0]  exq[$];          // expected status nibbles
	int          n_mismatch = 0;
	int          n_checks = 0;
	// pin, event, hole-mismatch flag and expected status per case
	localparam logic [31:0] TC [21] = '{32'h0800000a, 32'h0400000a, 32'h0000400a, 32'h0000200a,
		32'h0000100a, 32'h0200000c, 32'h0100000c, 32'h0080000c, 32'h00000c0c, 32'h00000019,
		32'h00020009, 32'h00010009, 32'h00008009, 32'h0a02001a, 32'h0202001c, 32'h00000000,
		32'h00001000, 32'h02000000, 32'h0000020c, 32'h00004000, 32'h0000410a};
	always #2.5 clk = ~clk;
	// memory channel events merge with the bench's own
	always_comb begin
		evw = sync_events_t'(ev_q);
		evw.mem_grant = grant;
		evw.image_done = done;
	end
	card_reader_abnormal_indicators #(.COLUMNS(80), .HOLE_W(10)) dut_u (.clk(clk), .rst_n(rst_n),
		.pins(transport_pins_t'(pin_q)), .ev(evw), .holes_rs1(h1), .holes_rs2(h2), .holes_valid(hv),
		.reg_addr(addr), .reg_wdata(wd), .reg_we(we), .reg_re(re), .reg_rdata(rdata), .data_error_ind(),
		.fault_ind(), .oversight_ind(), .mem_inhibit(inh), .standby_fetch(), .drive_motor(),
		.stacker_section_route(), .divert_to_stacker0(), .lamps());
	mem_channel_model mem_u (.clk(clk), .rst_n(rst_n), .start(st), .n_grant(ng), .slow(slow),
		.mem_inhibit(inh), .grant(grant), .done(done));
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic chk(input logic [3:0] s, input logic [3:0] e);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// one bus cycle; a read notes its expected answer
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] e);
		@(posedge clk);
		addr <= a;
		wd <= d;
		we <= w;
		re <= !w;
		if (!w) exq.push_back(e);
		@(posedge clk);
		we <= 1'h0;
		re <= 1'h0;
	endtask
	// card cycle boundary, status read, then operator and program clear
	task automatic finish(input logic [3:0] x);
		pin_q <= base | 12'h200;
		cyc(4);
		pin_q <= base;
		cyc(4);
		bus(1'h0, STATUS_OFS, 32'h0, x);
		pin_q <= base | 12'h004;
		cyc(4);
		pin_q <= base;
		cyc(3);
		// program resets only after the clear button
		bus(1'h1, STATUS_OFS, 32'h7, 4'h0);
		cyc(3);
		bus(1'h0, STATUS_OFS, 32'h0, 4'h0);
	endtask
	task automatic abn(input logic [31:0] t);
		lf = lfsr(lf);
		// a new online state must pass the pin synchronisers before any event
		@(posedge clk);
		pin_q <= base;
		cyc(3);
		pin_q <= base | t[31:20];
		ev_q <= t[19:8];
		h1 <= lf[9:0];
		h2 <= lf[9:0] ^ {9'h000, t[4]};
		hv <= 1'h1;
		@(posedge clk);
		ev_q <= 12'h000;
		hv <= 1'h0;
		cyc(4);
		pin_q <= base;
		cyc(3);
		finish(t[3:0]);
	endtask
	task automatic img(input logic [9:0] n, input logic s, input logic [3:0] x);
		@(posedge clk);
		ng <= n;
		slow <= s;
		st <= 1'h1;
		@(posedge clk);
		st <= 1'h0;
		for (int k = 0; k < 2000; k++) begin
			@(posedge clk);
			if (done === 1'h1) break;
			// a stalled channel is a failure, not a silent pass
			if (k == 1999) n_mismatch++;
		end
		finish(x);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// answer watcher: oldest note against the read data
	always @(posedge clk) begin
		rd_q <= re;
		if (rd_q) chk(rdata[3:0], exq.pop_front());
	end
	// watchdog sized well above the whole sequence
	initial begin
		#100000;
		n_mismatch++;
		complete_run();
	end
	initial begin
		cyc(6);
		rst_n <= 1'h1;
		pin_q <= base;
		cyc(4);
		bus(1'h1, CONTROL_OFS, 32'h2, 4'h0);
		bus(1'h0, CONTROL_OFS, 32'h0, 4'h2);
		bus(1'h0, 4'hc, 32'h0, 4'h0);
		$display("register port test done");
		// cases 16-18 run offline, 19-20 online with an empty feed path
		for (int i = 0; i < 21; i++) begin
			base = (i < 16) ? 12'hc00 : (i < 19) ? 12'h000 : 12'h800;
			abn(TC[i]);
			$display("case %0d done", i);
		end
		base = 12'hc00;
		img(10'h1e0, 1'h1, 4'h0);
		img(10'h1df, 1'h0, 4'h9);
		img(10'h1e1, 1'h0, 4'h9);
		$display("image count cases done");
		cyc(4);
		complete_run();
	end
endmodule
`default_nettype wire
